// file: core/nand_host_pkg.sv
package nand_host_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int unsigned PAGES_PER_BLOCK = 64;
  localparam int unsigned MAIN_BYTES      = 4096;
  localparam int unsigned SPARE_BYTES     = 128;
  localparam int unsigned PAGE_BYTES      = MAIN_BYTES + SPARE_BYTES;
  localparam int unsigned TOTAL_BLOCKS    = 8192;
  localparam int unsigned MIN_GOOD_BLOCKS = 8032;
  localparam int unsigned COL_W           = 13;
  localparam int unsigned BLK_W           = 13;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned RECOVERY_US     = 10;
  localparam int unsigned RECOVERY_CYC    =
    (RECOVERY_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STROBE_CYC      = 2;
  localparam int unsigned CNT_W           = 16;

  // ****************************************************************
  // Cycle kinds presented on the user port
  // ****************************************************************
  localparam logic [1:0] KIND_CMD  = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [1:0] KIND_READ = 2'h3;

  typedef enum logic [4:0] {
    ST_RECOVER = 5'h01,
    ST_IDLE    = 5'h02,
    ST_SETUP   = 5'h04,
    ST_STROBE  = 5'h08,
    ST_HOLD    = 5'h10
  } bus_state_e;

  // Column wrap for the counter that mirrors the device one.
  function automatic logic [COL_W-1:0] next_column(
    input logic [COL_W-1:0] col
  );
    next_column = (col == COL_W'(PAGE_BYTES - 1)) ? '0 : col + 1'b1;
  endfunction : next_column

endpackage : nand_host_pkg

// file: core/strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Down counter that paces strobe phases and power recovery
// ****************************************************************
module strobe_timer
  import nand_host_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  output logic                  done_o
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = value_i;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Done looks at the count alone: folding the load in would loop back
  // through the sequencer, which loads on done.
  assign done_o = (count == '0);
endmodule : strobe_timer
`default_nettype wire

// file: core/nand_host.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Host maps out bad blocks itself.
// - Dice run independently; other die usable.
// - Address select high marks address cycle.
// - Command select high marks command cycle.
// - No commands for 10 us after power.
// - Hold write strobe high during recovery.
// - Hold write protect low at power.
// - Open-drain busy; shared low means any busy.
module nand_host
  import nand_host_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             req_valid_i,
  input  wire logic [1:0]       req_kind_i,
  input  wire logic             req_die_i,
  input  wire logic [7:0]       req_data_i,
  output logic                  req_ready_o,
  output logic                  rd_valid_o,
  output logic [7:0]            rd_data_o,
  output logic [COL_W-1:0]      column_o,
  input  wire logic             wp_allow_i,
  input  wire logic             bad_block_i,
  output logic                  die_busy_o,
  output logic [1:0]            die_ready_o,
  input  wire logic [7:0]       shared_bus_lines_i,
  output logic [7:0]            shared_bus_lines_o,
  output logic                  shared_bus_lines_oe_o,
  output logic                  cmd_cycle_select_o,
  output logic                  addr_cycle_select_o,
  output logic                  die0_select_n_o,
  output logic                  die1_select_n_o,
  output logic                  read_strobe_n_o,
  output logic                  write_strobe_n_o,
  output logic                  write_protect_n_o,
  input  wire logic             die0_busy_n_i,
  input  wire logic             die1_busy_n_i
);
  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  bus_state_e       state;
  bus_state_e       next_state;
  logic [1:0]       kind;
  logic [1:0]       next_kind;
  logic             die;
  logic             next_die;
  logic [7:0]       dout;
  logic [7:0]       next_dout;
  logic [7:0]       rdat;
  logic [7:0]       next_rdat;
  logic             rvld;
  logic             next_rvld;
  logic [COL_W-1:0] col;
  logic [COL_W-1:0] next_col;
  logic             oe;
  logic             next_oe;
  logic             cle;
  logic             next_cle;
  logic             ale;
  logic             next_ale;
  logic [1:0]       sel_n;
  logic [1:0]       next_sel_n;
  logic             re_n;
  logic             next_re_n;
  logic             we_n;
  logic             next_we_n;
  logic             wp_n;
  logic             next_wp_n;
  logic             tload;
  logic [CNT_W-1:0] tval;
  logic             tdone;
  logic [1:0]       ready;
  logic             boot;
  logic             next_boot;

  strobe_timer u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tload),
    .value_i (tval),
    .done_o  (tdone)
  );

  // A low on either busy line keeps that die off limits; the other die
  // stays usable, so only the addressed die is checked.
  assign ready = {die1_busy_n_i, die0_busy_n_i};
  assign die_ready_o = ready;
  assign die_busy_o  = !(&ready);
  assign req_ready_o = (state == ST_IDLE) && ready[req_die_i];

  always_comb begin
    next_state = state;
    next_kind  = kind;
    next_die   = die;
    next_dout  = dout;
    next_rdat  = rdat;
    next_rvld  = 1'b0;
    next_col   = col;
    next_oe    = oe;
    next_cle   = cle;
    next_ale   = ale;
    next_sel_n = sel_n;
    next_re_n  = re_n;
    next_we_n  = we_n;
    next_wp_n  = wp_n;
    tload      = 1'b0;
    tval       = CNT_W'(STROBE_CYC);
    unique case (state)
      ST_RECOVER: begin
        // Write strobe high and protect low until the interface recovers.
        next_we_n = 1'b1;
        next_wp_n = 1'b0;
        if (boot) begin
          // The full wait starts once reset has let go of the timer.
          tload = 1'b1;
          tval  = CNT_W'(RECOVERY_CYC);
        end else if (tdone) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Protect follows the user only while idle, never in recovery or mid-cycle, and a
        // block that the user flags as bad is never programmed or erased.
        next_wp_n = wp_allow_i && !bad_block_i;
        if (req_valid_i && ready[req_die_i]) begin
          next_kind  = req_kind_i;
          next_die   = req_die_i;
          next_dout  = req_data_i;
          next_sel_n = req_die_i ? 2'h1 : 2'h2;
          next_cle   = (req_kind_i == KIND_CMD);
          next_ale   = (req_kind_i == KIND_ADDR);
          // Neither select high gives a data cycle.
          next_oe    = (req_kind_i != KIND_READ);
          if (req_kind_i == KIND_CMD || req_kind_i == KIND_ADDR) begin
            next_col = '0;
          end
          tload      = 1'b1;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tdone) begin
          if (kind == KIND_READ) begin
            next_re_n = 1'b0;
          end else begin
            next_we_n = 1'b0;
          end
          tload      = 1'b1;
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tdone) begin
          if (kind == KIND_READ) begin
            // Sample before release; the device float follows.
            next_rdat = shared_bus_lines_i;
            next_rvld = 1'b1;
            next_re_n = 1'b1;
            next_col  = next_column(col);
          end else begin
            next_we_n = 1'b1;
          end
          tload      = 1'b1;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tdone) begin
          next_oe    = 1'b0;
          next_cle   = 1'b0;
          next_ale   = 1'b0;
          // Dropping select while busy is harmless: the die stays on.
          next_sel_n = 2'h3;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RECOVER;
      kind  <= KIND_CMD;
      die   <= 1'b0;
      dout  <= 8'h00;
      rdat  <= 8'h00;
      rvld  <= 1'b0;
      col   <= '0;
      oe    <= 1'b0;
      cle   <= 1'b0;
      ale   <= 1'b0;
      sel_n <= 2'h3;
      re_n  <= 1'b1;
      we_n  <= 1'b1;
      wp_n  <= 1'b0;
    end else begin
      state <= next_state;
      kind  <= next_kind;
      die   <= next_die;
      dout  <= next_dout;
      rdat  <= next_rdat;
      rvld  <= next_rvld;
      col   <= next_col;
      oe    <= next_oe;
      cle   <= next_cle;
      ale   <= next_ale;
      sel_n <= next_sel_n;
      re_n  <= next_re_n;
      we_n  <= next_we_n;
      wp_n  <= next_wp_n;
    end
  end

  // ****************************************************************
  // Recovery timer load at reset release
  // ****************************************************************
  // The recovery count is loaded the first cycle after reset, since the
  // timer itself clears to zero under reset.
  always_comb begin
    next_boot = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot <= 1'b1;
    end else begin
      boot <= next_boot;
    end
  end

  assign rd_valid_o            = rvld;
  assign rd_data_o             = rdat;
  assign column_o              = col;
  assign shared_bus_lines_o    = dout;
  assign shared_bus_lines_oe_o = oe;
  assign cmd_cycle_select_o    = cle;
  assign addr_cycle_select_o   = ale;
  assign die0_select_n_o       = sel_n[0];
  assign die1_select_n_o       = sel_n[1];
  assign read_strobe_n_o       = re_n;
  assign write_strobe_n_o      = we_n;
  assign write_protect_n_o     = wp_n;
endmodule : nand_host
`default_nettype wire

// file: verif/nand_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Pin order checks on the host side
// ****************************************************************
module nand_host_sva
  import nand_host_pkg::*;
(
  input wire logic clk_i, rst_i, req_die_i, req_ready_o, rd_valid_o,
  input wire logic die_busy_o, shared_bus_lines_oe_o, cmd_cycle_select_o,
  input wire logic addr_cycle_select_o, die0_select_n_o, die1_select_n_o,
  input wire logic read_strobe_n_o, write_strobe_n_o, write_protect_n_o,
  input wire logic die0_busy_n_i, die1_busy_n_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned since_reset;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      since_reset <= 0;
    else if (since_reset < RECOVERY_CYC)
      since_reset <= since_reset + 1;
  end
  property p_wr;
    !write_strobe_n_o |-> shared_bus_lines_oe_o &&
      (die0_select_n_o != die1_select_n_o);
  endproperty
  a_wr: assert property (p_wr) else $error("bad write cycle");
  property p_len;
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*2];
  endproperty
  a_len: assert property (p_len) else $error("short strobe");
  property p_sel;
    !write_strobe_n_o |=> $stable(cmd_cycle_select_o) &&
      $stable(addr_cycle_select_o) && $stable(die0_select_n_o) &&
      $stable(die1_select_n_o);
  endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  property p_flt;
    !read_strobe_n_o |-> !shared_bus_lines_oe_o && !cmd_cycle_select_o &&
      !addr_cycle_select_o;
  endproperty
  a_flt: assert property (p_flt) else $error("bus clash on read");
  property p_any;
    die_busy_o == !(die0_busy_n_i && die1_busy_n_i);
  endproperty
  a_any: assert property (p_any) else $error("busy merge wrong");
  property p_ref;
    (req_die_i ? !die1_busy_n_i : !die0_busy_n_i) |-> !req_ready_o;
  endproperty
  a_ref: assert property (p_ref) else $error("busy die taken");
  property p_rd;
    $rose(read_strobe_n_o) |-> ##[0:3] rd_valid_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read byte lost");
  property p_pwr;
    $fell(rst_i) |-> write_strobe_n_o && !write_protect_n_o;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power pins");
  property p_rec;
    req_ready_o |-> since_reset >= RECOVERY_CYC;
  endproperty
  a_rec: assert property (p_rec) else $error("early ready");
endmodule : nand_host_sva
bind nand_host nand_host_sva i_nand_host_sva (.clk_i, .rst_i, .req_die_i,
  .req_ready_o, .rd_valid_o, .die_busy_o, .shared_bus_lines_oe_o,
  .cmd_cycle_select_o, .addr_cycle_select_o, .die0_select_n_o,
  .die1_select_n_o, .read_strobe_n_o, .write_strobe_n_o,
  .write_protect_n_o, .die0_busy_n_i, .die1_busy_n_i);
`default_nettype wire

// file: verif/nand_die_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// One die at its pins
// ****************************************************************
module nand_die_model
  import nand_host_pkg::*;
#(parameter int REC_CYC = 40, parameter int BUSY_CYC = 60) (
  input  wire logic       clk_i, rst_i, sel_n_i, cmd_sel_i, addr_sel_i,
  input  wire logic       we_n_i, re_n_i, wp_n_i,
  input  wire logic [7:0] bus_i,
  output logic [7:0]      bus_o,
  output logic            drive_o, busy_n_o,
  output logic [9:0]      cap_o
);
  logic       we_q, re_q;
  logic [7:0] col, out;
  int         cnt;
  assign busy_n_o = (cnt == 0);
  assign drive_o  = !sel_n_i && !re_n_i;
  // A released bus shows the inverse, so a stale byte cannot pass.
  assign bus_o    = drive_o ? out : ~out;
  always_ff @(posedge clk_i) begin
    we_q <= we_n_i;
    re_q <= re_n_i;
    // Reset stands for a supply below the lockout level: nothing is taken.
    if (rst_i) begin
      cnt   <= REC_CYC;
      col   <= 8'h00;
      out   <= 8'hFF;
      cap_o <= 10'h000;
    end else begin
      // Work goes on even when the host lets the select go.
      if (cnt != 0)
        cnt <= cnt - 1;
      if (!sel_n_i && !we_q && we_n_i) begin
        if (cmd_sel_i) begin
          cap_o <= {KIND_CMD, bus_i};
          col   <= 8'h00;
          cnt   <= BUSY_CYC;
        end else if (addr_sel_i) begin
          cap_o <= {KIND_ADDR, bus_i};
          col   <= 8'h00;
        end else if (wp_n_i) begin
          cap_o <= {KIND_DATA, bus_i};
        end
      end
      if (!sel_n_i && re_q && !re_n_i) begin
        out <= col;
        col <= col + 8'h01;
      end
    end
  end
endmodule : nand_die_model
`default_nettype wire

// file: verif/nand_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nand_host_tb_top;
  import nand_host_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic             clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0;
  logic             req_die_i = 1'b0, wp_allow_i = 1'b0, bad_block_i = 1'b0;
  logic [1:0]       req_kind_i = 2'h0, die_ready_o, drv, sel_n, busy_n;
  logic [7:0]       req_data_i = 8'h00, rd_data_o, bus_o, bus_in, mbus [2];
  logic [9:0]       cap [2];
  logic [COL_W-1:0] column_o;
  logic             req_ready_o, rd_valid_o, die_busy_o, oe, csel, asel;
  logic             ren, wen, wpn;
  int               miscompares = 0, checks = 0;
  assign bus_in = oe ? bus_o : (drv[1] ? mbus[1] : mbus[0]);
  nand_host i_nand_host (.clk_i, .rst_i, .req_valid_i, .req_kind_i,
    .req_die_i, .req_data_i, .req_ready_o, .rd_valid_o, .rd_data_o,
    .column_o, .wp_allow_i, .bad_block_i, .die_busy_o, .die_ready_o,
    .shared_bus_lines_i(bus_in), .shared_bus_lines_o(bus_o),
    .shared_bus_lines_oe_o(oe), .cmd_cycle_select_o(csel),
    .addr_cycle_select_o(asel), .die0_select_n_o(sel_n[0]),
    .die1_select_n_o(sel_n[1]), .read_strobe_n_o(ren),
    .write_strobe_n_o(wen), .write_protect_n_o(wpn),
    .die0_busy_n_i(busy_n[0]), .die1_busy_n_i(busy_n[1]));
  for (genvar g = 0; g < 2; g++) begin : g_die
    nand_die_model i_nand_die_model (.clk_i, .rst_i, .sel_n_i(sel_n[g]),
      .cmd_sel_i(csel), .addr_sel_i(asel), .we_n_i(wen), .re_n_i(ren),
      .wp_n_i(wpn), .bus_i(bus_in), .bus_o(mbus[g]), .drive_o(drv[g]),
      .busy_n_o(busy_n[g]), .cap_o(cap[g]));
  end
  initial forever #2.5 clk_i = ~clk_i;
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic hang;
    miscompares++;
    $display("ERROR %0t wait ran out", $time);
    give_verdict();
  endtask : hang
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [1:0] k, input logic d,
                      input logic [7:0] b);
    int n;
    @(posedge clk_i);
    req_kind_i  <= k;
    req_die_i   <= d;
    req_data_i  <= b;
    req_valid_i <= 1'b1;
    for (n = 0; n == 0 || req_ready_o !== 1'b1; n++) begin
      if (n == 200) hang();
      @(negedge clk_i);
    end
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask : send
  task automatic rd(input logic d, input logic [7:0] exp);
    int n;
    send(KIND_READ, d, 8'h00);
    for (n = 0; n == 0 || rd_valid_o !== 1'b1; n++) begin
      if (n == 50) hang();
      @(negedge clk_i);
    end
    chk(rd_data_o, exp);
  endtask : rd
  task automatic t_power;
    int   n;
    logic in_time;
    @(negedge clk_i);
    chk({sel_n, wen, ren, wpn, oe}, 6'h3C);
    chk(req_ready_o, 1'b0);
    for (n = 0; req_ready_o !== 1'b1; n++) begin
      if (n == RECOVERY_CYC + 100) hang();
      if (n == RECOVERY_CYC / 2) chk({wen, wpn}, 2'h2);
      @(negedge clk_i);
    end
    // The interface may open no sooner than the recovery time allows.
    in_time = (n >= RECOVERY_CYC) && (n <= RECOVERY_CYC + 8);
    chk(in_time, 1'b1);
    $display("t_power done");
  endtask : t_power
  task automatic t_par;
    @(posedge clk_i);
    wp_allow_i <= 1'b1;
    send(KIND_CMD, 1'b0, 8'h5A);
    send(KIND_ADDR, 1'b1, 8'hC3);
    repeat (12) @(negedge clk_i);
    chk(cap[0], {KIND_CMD, 8'h5A});
    chk(cap[1], {KIND_ADDR, 8'hC3});
    chk({die_busy_o, die_ready_o, req_ready_o}, 4'hD);
    @(posedge clk_i);
    req_die_i <= 1'b0;
    @(negedge clk_i);
    chk(req_ready_o, 1'b0);
    send(KIND_DATA, 1'b1, 8'h96);
    wp_allow_i <= 1'b0;
    // Protect drops between bytes; a refused byte leaves the latch alone.
    send(KIND_DATA, 1'b1, 8'h33);
    repeat (12) @(negedge clk_i);
    chk({wpn, cap[1]}, {1'b0, KIND_DATA, 8'h96});
    @(posedge clk_i);
    wp_allow_i  <= 1'b1;
    bad_block_i <= 1'b1;
    send(KIND_DATA, 1'b1, 8'h77);
    repeat (12) @(negedge clk_i);
    chk({wpn, cap[1]}, {1'b0, KIND_DATA, 8'h96});
    @(posedge clk_i);
    bad_block_i <= 1'b0;
    $display("t_par done");
  endtask : t_par
  task automatic t_read;
    send(KIND_CMD, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) rd(1'b1, 8'(i));
    repeat (3) @(negedge clk_i);
    chk(column_o, 13'h0003);
    $display("t_read done");
  endtask : t_read
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power();
    t_par();
    t_read();
    give_verdict();
  end
endmodule : nand_host_tb_top
`default_nettype wire
